//--- rtl/hdlc_regs_pkg.sv
// shared constants and types for the hdlc channel register block
package hdlc_regs_pkg;
    localparam int ADDR_W = 10;
    // register byte offsets
    localparam logic [9:0] RX_STATUS_OFF = 10'h300;
    localparam logic [9:0] TX_STATUS_OFF = 10'h304;
    localparam logic [9:0] CONFIG_ONE_OFF = 10'h308;
    localparam logic [9:0] CONFIG_TWO_OFF = 10'h30c;
    localparam logic [9:0] RX_CTRL_OFF = 10'h310;
    localparam logic [9:0] RX_NOWAIT_OFF = 10'h314;
    localparam logic [9:0] RX_STALL_OFF = 10'h318;
    localparam logic [9:0] TX_CTRL_OFF = 10'h31c;
    localparam logic [9:0] TX_NOWAIT_OFF = 10'h320;
    localparam logic [9:0] TX_STALL_OFF = 10'h324;
    // tx status fields
    localparam int TXS_BLOCK_BIT = 2;
    localparam int TXS_ABORT_BIT = 1;
    localparam int TXS_READY_BIT = 0;
    // rx status fields
    localparam int RXS_BLOCK_BIT = 6;
    localparam int RXS_END_BIT = 5;
    localparam int RXS_LEN_LSB = 3;
    localparam int RXS_ABORT_BIT = 2;
    localparam int RXS_EOP_BIT = 1;
    localparam int RXS_READY_BIT = 0;
    // config one fields
    localparam int C1_TX_BLOCK_EN_BIT = 19;
    localparam int C1_TX_ABORT_EN_BIT = 18;
    localparam int C1_TX_READY_EN_BIT = 17;
    localparam int C1_RX_BLOCK_EN_BIT = 16;
    localparam int C1_RX_END_EN_BIT = 15;
    localparam int C1_RX_ABORT_EN_BIT = 14;
    localparam int C1_RX_READY_EN_BIT = 13;
    localparam int C1_TX_EN_BIT = 12;
    localparam int C1_RX_EN_BIT = 11;
    localparam int C1_GLOBAL_EN_BIT = 10;
    localparam int C1_LONG_BIT = 9;
    localparam int C1_LEN_CHECK_BIT = 4;
    localparam int C1_LITTLE_BIT = 1;
    localparam logic [31:0] CONFIG_ONE_MASK = 32'h000ffe12;
    localparam logic [31:0] CONFIG_ONE_RESET = 32'h00000000;
    // config two, rx control, tx control fields
    localparam int C2_CRC_BIT = 0;
    localparam logic C2_CRC_RESET = 1'h0;
    localparam int RXC_DISCARD_BIT = 0;
    localparam int TXC_LEN_LSB = 2;
    localparam int TXC_DISCARD_BIT = 1;
    localparam int TXC_EOP_BIT = 0;
    localparam logic [1:0] TX_LEN_RESET = 2'h0;
    localparam logic TX_EOP_RESET = 1'h0;

    typedef struct packed {
        logic [31:0] data;
        logic eop;
        logic [1:0] len;
    } hdlc_word_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RX_WAIT = 3'b010,
        ST_TX_WAIT = 3'b100
    } cpu_state_t;
endpackage

//--- rtl/reset_release.sv
// two-stage release of the asynchronous reset
`timescale 1ns/1ps
module reset_release (
    // clock and raw reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // released reset
    output logic resetn_out
);
    logic stage_q;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stage_q <= 1'b0;
            resetn_out <= 1'b0;
        end else begin
            stage_q <= 1'b1;
            resetn_out <= stage_q;
        end
    end
endmodule

//--- rtl/word_buffer2.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module word_buffer2 (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // fill side
    input wire logic in_valid_in,
    input wire hdlc_regs_pkg::hdlc_word_t in_word_in,
    output logic in_ready_out,
    // drain side
    output logic out_valid_out,
    output hdlc_regs_pkg::hdlc_word_t out_word_out,
    input wire logic out_ready_in
);
    hdlc_regs_pkg::hdlc_word_t mem_q [2];
    logic wr_idx_q;
    logic rd_idx_q;
    logic [1:0] count_q;
    logic push;
    logic pop;
    logic [1:0] count_d;

    assign push = in_valid_in && in_ready_out;
    assign pop = out_ready_in && out_valid_out;
    assign out_valid_out = (count_q != 2'h0);
    assign out_word_out = mem_q[rd_idx_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 2'h1;
        end else if (pop && !push) begin
            count_d = count_q - 2'h1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_q <= 2'h0;
            in_ready_out <= 1'b0;
            wr_idx_q <= 1'b0;
            rd_idx_q <= 1'b0;
        end else begin
            count_q <= count_d;
            in_ready_out <= (count_d != 2'h2);
            if (push) begin
                wr_idx_q <= ~wr_idx_q;
            end
            if (pop) begin
                rd_idx_q <= ~rd_idx_q;
            end
        end
    end

    // storage carries no reset; out_word_out shows mem_q[rd_idx_q] even when no entry is valid
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_idx_q] <= in_word_in;
        end
    end
endmodule

//--- rtl/hdlc_channel_regs.sv
// cpu-facing register block for the hdlc slow control channel
// Summary of operation
// (R1) tx block-ready bit shows eight-word room
// (R2) tx abort bit shows aborted tx packet
// (R3) tx word-ready bit shows one-word room
// (R4) tx interrupts need source, global, tx enables
// (R5) rx interrupts need source, global, rx enables
// (R6) global, tx, rx enables are rw bits
// (R7) frames over 1536 bytes only if enabled
// (R8) length check drops packets under 64 bytes
// (R9) byte-order bit selects little endian data
// (R10) crc enable appends crc to frames
// (R11) rx discard write drops current rx frame
// (R12) empty no-wait rx read aborts the packet
// (R13) stall rx read waits unless cpu quits
// (R14) final-word length gives valid bytes minus one
// (R15) tx discard write drops current tx frame
// (R16) tx eop set before writing last word
// (R17) rx status gives ready, block, end, abort
// (R18) no-wait tx write without room aborts packet
// (R19) interrupt is or of qualified sources
// (R20) discard bits pulse once, read zero
`timescale 1ns/1ps
module hdlc_channel_regs (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // cpu port
    input wire logic [9:0] cpu_addr_in,
    input wire logic cpu_read_in,
    input wire logic cpu_write_in,
    input wire logic [31:0] cpu_wdata_in,
    output logic [31:0] cpu_rdata_out,
    output logic cpu_ack_out,
    // receive framer side
    input wire logic rx_word_valid_in,
    input wire hdlc_regs_pkg::hdlc_word_t rx_word_in,
    output logic rx_word_ready_out,
    input wire logic rx_block_ready_in,
    input wire logic rx_end_ready_in,
    input wire logic rx_abort_in,
    // transmit framer side
    output logic tx_word_valid_out,
    output hdlc_regs_pkg::hdlc_word_t tx_word_out,
    input wire logic tx_word_ready_in,
    input wire logic tx_block_ready_in,
    input wire logic tx_abort_in,
    // framer controls and interrupt
    output logic long_frame_en_out,
    output logic length_check_out,
    output logic little_endian_out,
    output logic crc_enable_out,
    output logic rx_discard_out,
    output logic tx_discard_out,
    output logic rx_abort_req_out,
    output logic tx_abort_req_out,
    output logic irq_out
);
    logic rst_n;
    logic [31:0] cfg1_q;
    logic crc_q;
    logic tx_eop_q;
    logic [1:0] tx_len_q;
    hdlc_regs_pkg::cpu_state_t state_q;
    logic buf_valid;
    logic buf_pop;
    hdlc_regs_pkg::hdlc_word_t buf_word;
    logic take;
    logic take_rd;
    logic take_wr;
    logic rx_pop_now;
    logic tx_push_now;
    logic [31:0] read_mux;
    logic [6:0] rx_status;
    logic [2:0] tx_status;
    logic tx_irq_term;
    logic rx_irq_term;

    function automatic logic [31:0] order_bytes(input logic [31:0] w, input logic little);
        order_bytes = little ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    endfunction

    reset_release u_reset (
        .clk_in(clk_sys_in),
        .resetn_in(resetn_in),
        .resetn_out(rst_n)
    );

    // lets the framer run ahead of a slow cpu without losing words
    word_buffer2 u_rx_buf (
        .clk_in(clk_sys_in),
        .resetn_in(rst_n),
        .in_valid_in(rx_word_valid_in),
        .in_word_in(rx_word_in),
        .in_ready_out(rx_word_ready_out),
        .out_valid_out(buf_valid),
        .out_word_out(buf_word),
        .out_ready_in(buf_pop)
    );

    // a request is taken only when idle and not in its own ack cycle
    assign take = (state_q == hdlc_regs_pkg::ST_IDLE) && !cpu_ack_out;
    assign take_rd = take && cpu_read_in;
    assign take_wr = take && cpu_write_in && !cpu_read_in;

    assign rx_pop_now = buf_valid && ((take_rd && (cpu_addr_in == hdlc_regs_pkg::RX_NOWAIT_OFF
        || cpu_addr_in == hdlc_regs_pkg::RX_STALL_OFF))
        || (state_q == hdlc_regs_pkg::ST_RX_WAIT && cpu_read_in));
    assign buf_pop = rx_pop_now;

    assign tx_push_now = !tx_word_valid_out && ((take_wr
        && (cpu_addr_in == hdlc_regs_pkg::TX_NOWAIT_OFF
        || cpu_addr_in == hdlc_regs_pkg::TX_STALL_OFF))
        || (state_q == hdlc_regs_pkg::ST_TX_WAIT && cpu_write_in));

    always_comb begin
        rx_status = 7'h0;
        rx_status[hdlc_regs_pkg::RXS_BLOCK_BIT] = rx_block_ready_in; // R17
        rx_status[hdlc_regs_pkg::RXS_END_BIT] = rx_end_ready_in; // R17
        rx_status[hdlc_regs_pkg::RXS_LEN_LSB +: 2] = buf_word.len;
        rx_status[hdlc_regs_pkg::RXS_ABORT_BIT] = rx_abort_in; // R17
        rx_status[hdlc_regs_pkg::RXS_EOP_BIT] = buf_valid && buf_word.eop; // R17
        rx_status[hdlc_regs_pkg::RXS_READY_BIT] = buf_valid; // R17
        tx_status = 3'h0;
        tx_status[hdlc_regs_pkg::TXS_BLOCK_BIT] = tx_block_ready_in; // R1
        tx_status[hdlc_regs_pkg::TXS_ABORT_BIT] = tx_abort_in; // R2
        tx_status[hdlc_regs_pkg::TXS_READY_BIT] = !tx_word_valid_out; // R3
    end

    always_comb begin
        read_mux = 32'h0;
        case (cpu_addr_in)
            hdlc_regs_pkg::RX_STATUS_OFF: read_mux = {25'h0, rx_status};
            hdlc_regs_pkg::TX_STATUS_OFF: read_mux = {29'h0, tx_status};
            hdlc_regs_pkg::CONFIG_ONE_OFF: read_mux = cfg1_q;
            hdlc_regs_pkg::CONFIG_TWO_OFF: read_mux = {31'h0, crc_q};
            hdlc_regs_pkg::TX_CTRL_OFF: read_mux = {28'h0, tx_len_q, 1'b0, tx_eop_q}; // R20
            default: read_mux = 32'h0; // R20
        endcase
    end

    // cpu access sequencing
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= hdlc_regs_pkg::ST_IDLE;
            cpu_ack_out <= 1'b0;
            cpu_rdata_out <= 32'h0;
            rx_abort_req_out <= 1'b0;
            tx_abort_req_out <= 1'b0;
        end else begin
            cpu_ack_out <= 1'b0;
            rx_abort_req_out <= 1'b0;
            tx_abort_req_out <= 1'b0;
            case (state_q)
                hdlc_regs_pkg::ST_IDLE: begin
                    if (take_rd) begin
                        if (cpu_addr_in == hdlc_regs_pkg::RX_NOWAIT_OFF) begin
                            cpu_ack_out <= 1'b1;
                            cpu_rdata_out <= buf_valid ?
                                order_bytes(buf_word.data, cfg1_q[hdlc_regs_pkg::C1_LITTLE_BIT]) :
                                32'h0; // R9
                            rx_abort_req_out <= !buf_valid; // R12
                        end else if (cpu_addr_in == hdlc_regs_pkg::RX_STALL_OFF && !buf_valid) begin
                            state_q <= hdlc_regs_pkg::ST_RX_WAIT; // R13
                        end else begin
                            cpu_ack_out <= 1'b1;
                            cpu_rdata_out <= (cpu_addr_in == hdlc_regs_pkg::RX_STALL_OFF) ?
                                order_bytes(buf_word.data, cfg1_q[hdlc_regs_pkg::C1_LITTLE_BIT]) :
                                read_mux;
                        end
                    end else if (take_wr) begin
                        if (cpu_addr_in == hdlc_regs_pkg::TX_STALL_OFF && tx_word_valid_out) begin
                            state_q <= hdlc_regs_pkg::ST_TX_WAIT;
                        end else begin
                            cpu_ack_out <= 1'b1;
                            tx_abort_req_out <= (cpu_addr_in == hdlc_regs_pkg::TX_NOWAIT_OFF)
                                && tx_word_valid_out; // R18
                        end
                    end
                end
                hdlc_regs_pkg::ST_RX_WAIT: begin
                    // dropping the read is the cpu's timeout; no answer is given
                    if (!cpu_read_in) begin
                        state_q <= hdlc_regs_pkg::ST_IDLE; // R13
                    end else if (buf_valid) begin
                        state_q <= hdlc_regs_pkg::ST_IDLE;
                        cpu_ack_out <= 1'b1;
                        cpu_rdata_out <= order_bytes(buf_word.data,
                            cfg1_q[hdlc_regs_pkg::C1_LITTLE_BIT]); // R9
                    end
                end
                hdlc_regs_pkg::ST_TX_WAIT: begin
                    if (!cpu_write_in) begin
                        state_q <= hdlc_regs_pkg::ST_IDLE;
                    end else if (!tx_word_valid_out) begin
                        state_q <= hdlc_regs_pkg::ST_IDLE;
                        cpu_ack_out <= 1'b1;
                    end
                end
                default: state_q <= hdlc_regs_pkg::ST_IDLE;
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            cfg1_q <= hdlc_regs_pkg::CONFIG_ONE_RESET;
            crc_q <= hdlc_regs_pkg::C2_CRC_RESET;
            tx_eop_q <= hdlc_regs_pkg::TX_EOP_RESET;
            tx_len_q <= hdlc_regs_pkg::TX_LEN_RESET;
        end else if (take_wr) begin
            if (cpu_addr_in == hdlc_regs_pkg::CONFIG_ONE_OFF) begin
                cfg1_q <= cpu_wdata_in & hdlc_regs_pkg::CONFIG_ONE_MASK; // R6
            end
            if (cpu_addr_in == hdlc_regs_pkg::CONFIG_TWO_OFF) begin
                crc_q <= cpu_wdata_in[hdlc_regs_pkg::C2_CRC_BIT];
            end
            if (cpu_addr_in == hdlc_regs_pkg::TX_CTRL_OFF) begin
                tx_eop_q <= cpu_wdata_in[hdlc_regs_pkg::TXC_EOP_BIT]; // R16
                tx_len_q <= cpu_wdata_in[hdlc_regs_pkg::TXC_LEN_LSB +: 2]; // R14
            end
        end
    end

    // framer option outputs, registered copies of the config bits
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            long_frame_en_out <= 1'b0;
            length_check_out <= 1'b0;
            little_endian_out <= 1'b0;
            crc_enable_out <= 1'b0;
        end else begin
            long_frame_en_out <= cfg1_q[hdlc_regs_pkg::C1_LONG_BIT]; // R7
            length_check_out <= cfg1_q[hdlc_regs_pkg::C1_LEN_CHECK_BIT]; // R8
            little_endian_out <= cfg1_q[hdlc_regs_pkg::C1_LITTLE_BIT]; // R9
            crc_enable_out <= crc_q; // R10
        end
    end

    // discard strobes store nothing
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            rx_discard_out <= 1'b0;
            tx_discard_out <= 1'b0;
        end else begin
            rx_discard_out <= take_wr && cpu_addr_in == hdlc_regs_pkg::RX_CTRL_OFF
                && cpu_wdata_in[hdlc_regs_pkg::RXC_DISCARD_BIT]; // R11 R20
            tx_discard_out <= take_wr && cpu_addr_in == hdlc_regs_pkg::TX_CTRL_OFF
                && cpu_wdata_in[hdlc_regs_pkg::TXC_DISCARD_BIT]; // R15 R20
        end
    end

    // transmit word hand-off; the eop mark stays until software clears it
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_word_valid_out <= 1'b0;
            tx_word_out <= '0;
        end else if (tx_push_now) begin
            tx_word_valid_out <= 1'b1;
            tx_word_out.data <= order_bytes(cpu_wdata_in, cfg1_q[hdlc_regs_pkg::C1_LITTLE_BIT]);
            tx_word_out.eop <= tx_eop_q; // R16
            tx_word_out.len <= tx_len_q; // R14
        end else if (tx_word_ready_in) begin
            tx_word_valid_out <= 1'b0;
        end
    end

    assign tx_irq_term = cfg1_q[hdlc_regs_pkg::C1_TX_EN_BIT]
        && ((cfg1_q[hdlc_regs_pkg::C1_TX_BLOCK_EN_BIT] && tx_status[hdlc_regs_pkg::TXS_BLOCK_BIT])
        || (cfg1_q[hdlc_regs_pkg::C1_TX_ABORT_EN_BIT] && tx_status[hdlc_regs_pkg::TXS_ABORT_BIT])
        || (cfg1_q[hdlc_regs_pkg::C1_TX_READY_EN_BIT] && tx_status[hdlc_regs_pkg::TXS_READY_BIT]));
    assign rx_irq_term = cfg1_q[hdlc_regs_pkg::C1_RX_EN_BIT]
        && ((cfg1_q[hdlc_regs_pkg::C1_RX_BLOCK_EN_BIT] && rx_status[hdlc_regs_pkg::RXS_BLOCK_BIT])
        || (cfg1_q[hdlc_regs_pkg::C1_RX_END_EN_BIT] && rx_status[hdlc_regs_pkg::RXS_END_BIT])
        || (cfg1_q[hdlc_regs_pkg::C1_RX_ABORT_EN_BIT] && rx_status[hdlc_regs_pkg::RXS_ABORT_BIT])
        || (cfg1_q[hdlc_regs_pkg::C1_RX_READY_EN_BIT] && rx_status[hdlc_regs_pkg::RXS_READY_BIT]));

    // level interrupt: follows the sources, nothing sticky to clear
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= cfg1_q[hdlc_regs_pkg::C1_GLOBAL_EN_BIT]
                && (tx_irq_term || rx_irq_term); // R4 R5 R19
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n);

    tx_irq_gate_a: assert property (!rx_irq_term && tx_irq_term // R4
        |=> irq_out == $past(cfg1_q[hdlc_regs_pkg::C1_GLOBAL_EN_BIT]))
        else $error("tx interrupt not gated by global enable");
    rx_irq_gate_a: assert property (!tx_irq_term && !rx_irq_term // R5
        |=> !irq_out) else $error("interrupt without qualified source");
    irq_hold_a: assert property (cfg1_q[hdlc_regs_pkg::C1_GLOBAL_EN_BIT] && rx_irq_term // R19
        ##1 cfg1_q[hdlc_regs_pkg::C1_GLOBAL_EN_BIT] |-> irq_out)
        else $error("interrupt dropped while source set");
    nowait_abort_a: assert property (take_rd && cpu_addr_in == hdlc_regs_pkg::RX_NOWAIT_OFF // R12
        && !buf_valid |=> rx_abort_req_out && cpu_ack_out && cpu_rdata_out == 32'h0)
        else $error("empty no-wait read did not abort");
    stall_wait_a: assert property (take_rd && cpu_addr_in == hdlc_regs_pkg::RX_STALL_OFF // R13
        && !buf_valid |=> !cpu_ack_out [*1] ##0 state_q == hdlc_regs_pkg::ST_RX_WAIT)
        else $error("stall read answered without data");
    rx_discard_a: assert property (take_wr && cpu_addr_in == hdlc_regs_pkg::RX_CTRL_OFF // R11
        && cpu_wdata_in[0] |=> rx_discard_out ##1 !rx_discard_out)
        else $error("rx discard not a single pulse");
    tx_discard_a: assert property (tx_discard_out |-> $past(take_wr) // R15
        && $past(cpu_addr_in) == hdlc_regs_pkg::TX_CTRL_OFF)
        else $error("tx discard without control write");
    long_frame_a: assert property (take_wr && cpu_addr_in == hdlc_regs_pkg::CONFIG_ONE_OFF // R7
        |=> ##1 long_frame_en_out == $past(cpu_wdata_in[9], 2))
        else $error("long frame enable not applied");
    tx_abort_a: assert property (take_wr && cpu_addr_in == hdlc_regs_pkg::TX_NOWAIT_OFF // R18
        && tx_word_valid_out |=> tx_abort_req_out) else $error("tx write into busy not aborted");
    tx_status_a: assert property (take_rd && cpu_addr_in == hdlc_regs_pkg::TX_STATUS_OFF // R1
        |=> cpu_rdata_out[2:0] == {$past(tx_block_ready_in), $past(tx_abort_in),
        !$past(tx_word_valid_out)}) else $error("tx status mismatch");
    discard_zero_a: assert property (take_rd && cpu_addr_in == hdlc_regs_pkg::RX_CTRL_OFF // R20
        |=> cpu_rdata_out == 32'h0) else $error("discard register not zero");
    eop_word_a: assert property (tx_push_now |=> tx_word_out.eop == $past(tx_eop_q)) // R16
        else $error("tx word lost its eop mark");

    stall_done_c: cover property (state_q == hdlc_regs_pkg::ST_RX_WAIT ##1 cpu_ack_out);
    buf_full_c: cover property (!rx_word_ready_out && rx_word_valid_in);
    irq_c: cover property (!irq_out ##1 irq_out);
endmodule

//--- verif/framer_model.sv
// far-side framer model: rx word source and stalling tx word sink
`timescale 1ns/1ps
module framer_model (
    // clock
    input wire logic clk_in,
    // rx stream toward the block
    output logic rx_valid_out,
    output hdlc_regs_pkg::hdlc_word_t rx_word_out,
    input wire logic rx_ready_in,
    // tx stream from the block
    input wire logic tx_valid_in,
    input wire hdlc_regs_pkg::hdlc_word_t tx_word_in,
    output logic tx_ready_out
);
    hdlc_regs_pkg::hdlc_word_t rxq[$];
    hdlc_regs_pkg::hdlc_word_t txq[$];
    bit stall = 0;
    initial begin
        rx_valid_out = 0;
        rx_word_out = '0;
        tx_ready_out = 0;
    end
    always @(posedge clk_in) begin
        if (tx_valid_in && tx_ready_out)
            txq.push_back(tx_word_in);
        if (rx_valid_out && rx_ready_in)
            void'(rxq.pop_front());
        rx_valid_out <= rxq.size() > 0;
        // idle word is scrambled so a stale value is never mistaken for data
        rx_word_out <= rxq.size() > 0 ? rxq[0] : ~rx_word_out;
        tx_ready_out <= !stall && $urandom_range(0, 1);
    end
endmodule

//--- verif/test_hdlc_channel_regs.sv
// self-checking bench for the hdlc channel register block
`timescale 1ns/1ps
module test_hdlc_channel_regs;
    logic clk_sys_in = 0;
    logic resetn_in = 0;
    logic [9:0] cpu_addr_in = '0;
    logic cpu_read_in = 0;
    logic cpu_write_in = 0;
    logic [31:0] cpu_wdata_in = '0;
    logic [31:0] cpu_rdata_out;
    logic cpu_ack_out;
    logic rx_v, rx_r, tx_v, tx_r;
    hdlc_regs_pkg::hdlc_word_t rx_w, tx_w, w;
    hdlc_regs_pkg::hdlc_word_t exq[$];
    logic [4:0] lv = '0;
    logic lfe, lck, lte, crc, rxd, txd, rxa, txa, irq;
    logic [3:0] pulses;
    logic [31:0] rd, d;
    int failures = 0;
    int n_compared = 0;
    int cfg, i;
    int src[5] = '{19, 18, 16, 15, 14};
    always #4 clk_sys_in = ~clk_sys_in;
    hdlc_channel_regs hdlc_channel_regs_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .cpu_addr_in(cpu_addr_in), .cpu_read_in(cpu_read_in), .cpu_write_in(cpu_write_in),
        .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(cpu_rdata_out), .cpu_ack_out(cpu_ack_out),
        .rx_word_valid_in(rx_v), .rx_word_in(rx_w), .rx_word_ready_out(rx_r),
        .rx_block_ready_in(lv[2]), .rx_end_ready_in(lv[3]), .rx_abort_in(lv[4]),
        .tx_word_valid_out(tx_v), .tx_word_out(tx_w), .tx_word_ready_in(tx_r),
        .tx_block_ready_in(lv[0]), .tx_abort_in(lv[1]), .long_frame_en_out(lfe),
        .length_check_out(lck), .little_endian_out(lte), .crc_enable_out(crc),
        .rx_discard_out(rxd), .tx_discard_out(txd), .rx_abort_req_out(rxa),
        .tx_abort_req_out(txa), .irq_out(irq));
    framer_model framer_model_inst (.clk_in(clk_sys_in), .rx_valid_out(rx_v),
        .rx_word_out(rx_w), .rx_ready_in(rx_r), .tx_valid_in(tx_v), .tx_word_in(tx_w),
        .tx_ready_out(tx_r));
    task automatic end_sim;
        if (failures == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] sw(input logic [31:0] x, input logic le);
        return le ? {x[7:0], x[15:8], x[23:16], x[31:24]} : x;
    endfunction
    // request held until the ack is seen, dropped at the following edge
    task automatic cpu(input bit wr, input logic [9:0] a, input logic [31:0] x);
        int k;
        @(posedge clk_sys_in);
        cpu_addr_in <= a;
        cpu_wdata_in <= x;
        cpu_read_in <= !wr;
        cpu_write_in <= wr;
        for (k = 0; k < 300 && cpu_ack_out !== 1'b1; k++) begin
            @(posedge clk_sys_in);
            #1;
        end
        rd = cpu_rdata_out;
        pulses = {rxd, txd, rxa, txa};
        @(posedge clk_sys_in);
        cpu_read_in <= 0;
        cpu_write_in <= 0;
    endtask
    task automatic push;
        w = {$urandom(), 3'($urandom())};
        exq.push_back(w);
        framer_model_inst.rxq.push_back(w);
    endtask
    task automatic rdrx(input logic [9:0] a);
        cpu(0, a, 0);
        w = exq.pop_front();
        chk(rd, sw(w.data, 1'b1));
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        failures++;
        end_sim();
    end
    initial begin
        void'($urandom(35));
        repeat (5) @(posedge clk_sys_in);
        resetn_in <= 1;
        repeat (4) @(posedge clk_sys_in);
        for (i = 0; i < 4; i++) begin
            cpu(0, 10'h304 + 10'(4 * i), 0);
            chk(rd, i == 0);
        end
        repeat (3) begin
            cfg = $urandom();
            cpu(1, hdlc_regs_pkg::CONFIG_ONE_OFF, cfg);
            cpu(0, hdlc_regs_pkg::CONFIG_ONE_OFF, 0);
            chk(rd, cfg & hdlc_regs_pkg::CONFIG_ONE_MASK);
            chk({lfe, lck, lte}, {cfg[9], cfg[4], cfg[1]});
        end
        foreach (src[j]) begin
            cfg = j[0] ? 32'hfffffffe : 32'h1;
            cpu(1, hdlc_regs_pkg::CONFIG_TWO_OFF, cfg);
            cpu(0, hdlc_regs_pkg::CONFIG_TWO_OFF, 0);
            chk({rd, crc}, {31'h0, cfg[0], cfg[0]});
        end
        cpu(1, hdlc_regs_pkg::RX_CTRL_OFF, 32'h1);
        chk(pulses, 4'h8);
        cpu(0, hdlc_regs_pkg::RX_CTRL_OFF, 0);
        chk(rd, 0);
        cpu(1, hdlc_regs_pkg::TX_CTRL_OFF, 32'hf);
        chk(pulses, 4'h4);
        cpu(0, hdlc_regs_pkg::TX_CTRL_OFF, 0);
        chk(rd, 32'hd);
        for (i = 0; i < 2; i++) begin
            cpu(1, hdlc_regs_pkg::CONFIG_ONE_OFF, 32'(i << 1));
            cfg = $urandom() & 32'hd;
            d = $urandom();
            cpu(1, hdlc_regs_pkg::TX_CTRL_OFF, cfg);
            cpu(1, i ? hdlc_regs_pkg::TX_STALL_OFF : hdlc_regs_pkg::TX_NOWAIT_OFF, d);
            repeat (20) @(posedge clk_sys_in);
            w = framer_model_inst.txq.pop_front();
            chk(w, {sw(d, i[0]), cfg[0], cfg[3:2]});
        end
        lv <= 5'(3'($urandom()));
        framer_model_inst.stall = 1;
        cpu(1, hdlc_regs_pkg::TX_NOWAIT_OFF, $urandom());
        cpu(0, hdlc_regs_pkg::TX_STATUS_OFF, 0);
        chk(rd, {lv[0], lv[1], 1'b0});
        cpu(1, hdlc_regs_pkg::TX_NOWAIT_OFF, $urandom());
        chk(pulses[0], 1);
        framer_model_inst.stall = 0;
        repeat (20) @(posedge clk_sys_in);
        framer_model_inst.txq.delete();
        cpu(0, hdlc_regs_pkg::TX_STATUS_OFF, 0);
        chk(rd, {lv[0], lv[1], 1'b1});
        repeat (3) push();
        repeat (8) @(posedge clk_sys_in);
        chk(rx_r, 0);
        cpu(0, hdlc_regs_pkg::RX_STATUS_OFF, 0);
        chk(rd, {lv[2], lv[3], exq[0].len, lv[4], exq[0].eop, 1'b1});
        repeat (3) rdrx(hdlc_regs_pkg::RX_NOWAIT_OFF);
        cpu(0, hdlc_regs_pkg::RX_NOWAIT_OFF, 0);
        chk({rd, pulses[1]}, 33'h1);
        fork
            rdrx(hdlc_regs_pkg::RX_STALL_OFF);
            begin
                repeat (20) @(posedge clk_sys_in);
                push();
            end
        join
        lv <= '0;
        for (i = 0; i < 5; i++) begin
            cfg = (1 << src[i]) | 32'h400;
            cpu(1, hdlc_regs_pkg::CONFIG_ONE_OFF, cfg | (i < 2 ? 32'h1000 : 32'h800));
            repeat (3) @(posedge clk_sys_in);
            chk(irq, 0);
            lv[i] <= 1;
            repeat (3) @(posedge clk_sys_in);
            chk(irq, 1);
            cpu(1, hdlc_regs_pkg::CONFIG_ONE_OFF, cfg);
            repeat (3) @(posedge clk_sys_in);
            chk(irq, 0);
            lv <= '0;
        end
        cpu(1, hdlc_regs_pkg::CONFIG_ONE_OFF, 32'h21400);
        repeat (3) @(posedge clk_sys_in);
        chk(irq, 1);
        end_sim();
    end
endmodule
